/* src/tma_bus_alarm_top.sv */
// Purpose: Slave side of the two-wire bus and the two alarm outputs of the monitor.
// Assumes: SCL and SDA arrive unsynchronised; temperatures and limits are unsigned codes.
// Notes:   Written bytes leave through a buffer as {pointer, data}; a full buffer NACKs.
//
// Functional notes
// RL1 - Both lines high means bus idle.
// RL2 - Detect START: SDA falls while SCL high.
// RL3 - Detect STOP and repeated START as boundaries.
// RL4 - No byte limit; acknowledge every received byte. The code NACKs a data byte while the write buffer is full.
// RL5 - Acknowledge holds SDA low through clock high.
// RL6 - Master NACKs last byte it reads.
// RL7 - High-speed code: no ACK, switch filters.
// RL8 - High-speed transfers accepted up to 3.4MHz.
// RL9 - High-speed lasts until STOP, then fast filtering.
// RL10 - Reset interface when line low 32ms.
// RL11 - On timeout release SDA, await START.
// RL12 - Open-drain alarms; only alert maskable.
// RL13 - Config bit 5 selects alert or second-critical.
// RL14 - Critical alarm above critical limit.
// RL15 - Critical release below limit minus hysteresis. The code releases at or below limit minus hysteresis.
// RL16 - Second critical uses high limits.
// RL17 - Alert on high or low limit violation.
// RL18 - Alert after 1 to 4 consecutive violations.
// RL19 - Alert also on open remote sensor.
// RL20 - Config bit 7 masks the alert pin.
// RL21 - Alert response clears ended alert.
// RL22 - Alert response: ACK, return address and cause.
// RL23 - Arbitration loser keeps its alert asserted.
// RL24 - First written byte loads the register pointer.
// RL25 - Hysteresis register at 21h, reset 0Ah.
// RL26 - Timeout counter clears when lines high.
// RL27 - Violation run counter clears on good result.
`timescale 1ns/1ns
`default_nettype none
module tma_bus_alarm_top #(
  parameter int TIMEOUT_CYCLES = tma_pkg::TIMEOUT_CYCLES,
  parameter int FIFO_DEPTH     = tma_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Two-wire bus
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output var  logic       sdaOut,
  output var  logic       sdaOe,
  input  wire logic [6:0] slaveAddr,
  output var  logic       highSpeedBusOperation,
  // Register access by the host side of the chip
  output var  logic [7:0] regPointer,
  input  wire logic [7:0] readData,
  output var  logic       wrValid,
  input  wire logic       wrReady,
  output var  logic [7:0] wrPointer,
  output var  logic [7:0] wrData,
  // Measurements and limits
  input  wire logic       convDone,
  input  wire logic [7:0] localTemp,
  input  wire logic [7:0] remoteTemp,
  input  wire logic [7:0] localCritLimit,
  input  wire logic [7:0] remoteCritLimit,
  input  wire logic [7:0] localHighLimit,
  input  wire logic [7:0] remoteHighLimit,
  input  wire logic [7:0] localLowLimit,
  input  wire logic [7:0] remoteLowLimit,
  input  wire logic       remoteOpen,
  input  wire logic [7:0] configBits,
  input  wire logic       statusCleared,
  // Alarm pins
  output var  logic       criticalAlarmOut,
  output var  logic       criticalAlarmOe,
  output var  logic       sharedAlarmPinOut,
  output var  logic       sharedAlarmPinOe
);
  // ------------
  // Types and helpers
  // ------------
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_ADDR    = 3'b001,
    S_ADDRACK = 3'b010,
    S_WRBYTE  = 3'b011,
    S_WRACK   = 3'b100,
    S_RDBYTE  = 3'b101,
    S_RDACK   = 3'b110
  } tma_state_t;

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  generate
    if (TIMEOUT_CYCLES < 2) begin : gBadTimeout
      $error("TIMEOUT_CYCLES too small");
    end
  endgenerate

  // True when a temperature has fallen to the limit minus the hysteresis.
  function automatic logic backInside(input logic [7:0] t, input logic [7:0] lim,
                                      input logic [7:0] h);
    backInside = ({1'b0, t} + {1'b0, h}) <= {1'b0, lim};
  endfunction

  // ------------
  // Line synchronisers and filters
  // ------------
  logic [1:0] sclMeta;
  logic [1:0] sdaMeta;
  logic [1:0] fCnt;
  logic       sclF;
  logic       sdaF;
  logic       sclPrev;
  logic       sdaPrev;
  logic [1:0] filtLen;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclMeta <= 2'h3;
      sdaMeta <= 2'h3;
    end else begin
      sclMeta <= {sclMeta[0], sclIn};
      sdaMeta <= {sdaMeta[0], sdaIn};
    end
  end

  // Fast mode demands a stable level for a few cycles; high speed passes at once.
  assign filtLen = highSpeedBusOperation ? 2'(tma_pkg::FILT_HS) : 2'(tma_pkg::FILT_FAST); // [RL7] [RL8] [RL9]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fCnt    <= 2'h0;
      sclF    <= 1'b1;
      sdaF    <= 1'b1;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclF;
      sdaPrev <= sdaF;
      if (sclMeta[1] == sclF && sdaMeta[1] == sdaF) begin
        fCnt <= 2'h0;
      end else if (fCnt >= filtLen) begin
        fCnt <= 2'h0;
        sclF <= sclMeta[1];
        sdaF <= sdaMeta[1];
      end else begin
        fCnt <= fCnt + 2'h1;
      end
    end
  end

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign sclRise   = sclF & ~sclPrev;
  assign sclFall   = ~sclF & sclPrev;
  assign startCond = sclF & sclPrev & sdaPrev & ~sdaF; // [RL2] [RL3]
  assign stopCond  = sclF & sclPrev & ~sdaPrev & sdaF; // [RL3]

  // ------------
  // Bus timeout
  // ------------
  logic          inXfer;
  logic [TW-1:0] toCnt;
  logic          timeoutHit;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      toCnt      <= '0;
      timeoutHit <= 1'b0;
    end else begin
      timeoutHit <= 1'b0;
      if (!inXfer || (sclF && sdaF)) begin // [RL1] [RL26]
        toCnt <= '0;
      end else if (toCnt == TW'(TIMEOUT_CYCLES - 1)) begin // [RL10]
        toCnt      <= '0;
        timeoutHit <= 1'b1;
      end else begin
        toCnt <= toCnt + TW'(1);
      end
    end
  end

  // ------------
  // Byte engine
  // ------------
  tma_stream_if #(.WIDTH(tma_pkg::FIFO_WIDTH)) pushIf ();
  tma_stream_if #(.WIDTH(tma_pkg::FIFO_WIDTH)) popIf ();

  tma_state_t state;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] txByte;
  logic       firstByte;
  logic       isRead;
  logic       ptrPhase;
  logic       araSel;
  logic       ackSeen;
  logic       araWon;
  logic       pushReq;
  logic [7:0] hystReg;
  logic [7:0] consecReg;
  logic       alertActive;
  logic       alertCause;
  logic [7:0] nextTx;

  always_comb begin
    if (araSel) begin
      nextTx = {slaveAddr, alertCause}; // [RL22]
    end else if (regPointer == tma_pkg::PTR_HYST) begin
      nextTx = hystReg;
    end else if (regPointer == tma_pkg::PTR_CONSEC) begin
      nextTx = consecReg;
    end else begin
      nextTx = readData;
    end
  end

  assign pushIf.valid = pushReq;
  assign pushIf.data  = {regPointer, shiftIn};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state                 <= S_IDLE;
      bitCnt                <= 4'h0;
      shiftIn               <= 8'h00;
      txByte                <= 8'h00;
      firstByte             <= 1'b0;
      isRead                <= 1'b0;
      ptrPhase              <= 1'b0;
      araSel                <= 1'b0;
      ackSeen               <= 1'b0;
      araWon                <= 1'b0;
      pushReq               <= 1'b0;
      inXfer                <= 1'b0;
      sdaOe                 <= 1'b0;
      sdaOut                <= 1'b0;
      highSpeedBusOperation <= 1'b0;
      regPointer            <= 8'h00;
      hystReg               <= tma_pkg::HYST_POR; // [RL25]
      consecReg             <= tma_pkg::CONSEC_POR;
    end else begin
      araWon  <= 1'b0;
      pushReq <= 1'b0;
      if (timeoutHit) begin
        state  <= S_IDLE; // [RL11]
        sdaOe  <= 1'b0;
        inXfer <= 1'b0;
      end else if (startCond) begin
        state     <= S_ADDR; // [RL2] [RL3]
        bitCnt    <= 4'h0;
        sdaOe     <= 1'b0;
        inXfer    <= 1'b1;
        araSel    <= 1'b0;
        firstByte <= 1'b1;
      end else if (stopCond) begin
        state                 <= S_IDLE; // [RL3]
        sdaOe                 <= 1'b0;
        inXfer                <= 1'b0;
        highSpeedBusOperation <= 1'b0; // [RL9]
      end else begin
        unique case (state)
          S_IDLE: begin
            sdaOe <= 1'b0;
          end
          S_ADDR: begin
            if (sclRise) begin
              shiftIn <= {shiftIn[6:0], sdaF};
              bitCnt  <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              firstByte <= 1'b0;
              isRead    <= shiftIn[0];
              if (firstByte && shiftIn[7:3] == tma_pkg::HS_CODE_TOP) begin
                highSpeedBusOperation <= 1'b1; // [RL7]
                state                 <= S_IDLE;
              end else if (shiftIn[7:1] == slaveAddr) begin
                sdaOe <= 1'b1; // [RL5]
                state <= S_ADDRACK;
              end else if (shiftIn == tma_pkg::ALERT_RESPONSE_BYTE && alertActive) begin
                sdaOe  <= 1'b1; // [RL22]
                araSel <= 1'b1;
                state  <= S_ADDRACK;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_ADDRACK: begin
            if (sclFall) begin
              bitCnt <= 4'h0;
              if (isRead) begin
                txByte <= nextTx;
                sdaOe  <= ~nextTx[7];
                state  <= S_RDBYTE;
              end else begin
                sdaOe    <= 1'b0;
                ptrPhase <= 1'b1;
                state    <= S_WRBYTE;
              end
            end
          end
          S_WRBYTE: begin
            if (sclRise) begin
              shiftIn <= {shiftIn[6:0], sdaF};
              bitCnt  <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              if (ptrPhase) begin
                regPointer <= shiftIn; // [RL24]
                ptrPhase   <= 1'b0;
                sdaOe      <= 1'b1; // [RL4]
                state      <= S_WRACK;
              end else if (pushIf.ready) begin
                pushReq <= 1'b1; // [RL4]
                sdaOe   <= 1'b1;
                state   <= S_WRACK;
                if (regPointer == tma_pkg::PTR_HYST) begin
                  hystReg <= shiftIn; // [RL25]
                end
                if (regPointer == tma_pkg::PTR_CONSEC) begin
                  consecReg <= shiftIn;
                end
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_WRACK: begin
            if (sclFall) begin
              sdaOe  <= 1'b0;
              bitCnt <= 4'h0;
              state  <= S_WRBYTE;
            end
          end
          S_RDBYTE: begin
            if (sclRise) begin
              bitCnt <= bitCnt + 4'h1;
              if (!sdaOe && !sdaF && araSel) begin
                state <= S_IDLE; // [RL23]
              end
            end else if (sclFall) begin
              if (bitCnt == 4'h8) begin
                sdaOe <= 1'b0;
                state <= S_RDACK;
              end else begin
                txByte <= {txByte[6:0], 1'b0};
                sdaOe  <= ~txByte[6];
              end
            end
          end
          S_RDACK: begin
            if (sclRise) begin
              ackSeen <= ~sdaF; // [RL6]
              if (araSel) begin
                araWon <= 1'b1; // [RL21] [RL23]
              end
            end else if (sclFall) begin
              bitCnt <= 4'h0;
              if (ackSeen && !araSel) begin
                txByte <= nextTx; // [RL6]
                sdaOe  <= ~nextTx[7];
                state  <= S_RDBYTE;
              end else begin
                state <= S_IDLE; // [RL6]
              end
            end
          end
        endcase
      end
    end
  end

  tma_fifo #(
    .WIDTH (tma_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .clock  (clock),
    .resetn (resetn),
    .push   (pushIf),
    .pop    (popIf)
  );

  assign popIf.ready = wrReady;
  assign wrValid     = popIf.valid;
  assign wrPointer   = popIf.data[15:8];
  assign wrData      = popIf.data[7:0];

  // ------------
  // Alarm evaluation
  // ------------
  logic       critActive;
  logic       crit2Active;
  logic [2:0] runCnt;
  logic       violHigh;
  logic       violLow;
  logic       lastViol;
  logic [2:0] runNeed;
  logic       functionSecondCrit;
  logic       alertMasked;
  logic       alertSet;
  logic       alertClr;

  assign functionSecondCrit = configBits[tma_pkg::CFG_FUNC_BIT]; // [RL13]
  assign alertMasked        = configBits[tma_pkg::CFG_MASK_BIT]; // [RL20]
  assign violHigh = (localTemp >= localHighLimit) | (remoteTemp >= remoteHighLimit);
  assign violLow  = (localTemp < localLowLimit) | (remoteTemp < remoteLowLimit); // [RL17]
  assign runNeed  = {1'b0, consecReg[tma_pkg::CALT_MSB:tma_pkg::CALT_LSB]} + 3'h1; // [RL18]
  assign alertSet = (convDone && (violHigh || violLow) && (runCnt + 3'h1 >= runNeed))
                    || remoteOpen; // [RL18] [RL19]
  assign alertClr = araWon && !lastViol && !remoteOpen && statusCleared; // [RL21]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      critActive  <= 1'b0;
      crit2Active <= 1'b0;
    end else if (convDone) begin
      if (localTemp > localCritLimit || remoteTemp > remoteCritLimit) begin
        critActive <= 1'b1; // [RL14]
      end else if (backInside(localTemp, localCritLimit, hystReg) &&
                   backInside(remoteTemp, remoteCritLimit, hystReg)) begin
        critActive <= 1'b0; // [RL15]
      end
      if (localTemp > localHighLimit || remoteTemp > remoteHighLimit) begin
        crit2Active <= 1'b1; // [RL16]
      end else if (backInside(localTemp, localHighLimit, hystReg) &&
                   backInside(remoteTemp, remoteHighLimit, hystReg)) begin
        crit2Active <= 1'b0; // [RL16]
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      runCnt   <= 3'h0;
      lastViol <= 1'b0;
    end else if (convDone) begin
      lastViol <= violHigh | violLow;
      if (!(violHigh || violLow)) begin
        runCnt <= 3'h0; // [RL27]
      end else if (runCnt != 3'h4) begin
        runCnt <= runCnt + 3'h1; // [RL18]
      end
    end
  end

  // A new cause in the same cycle as an alert response keeps the alert.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      alertActive <= 1'b0;
      alertCause  <= 1'b0;
    end else if (alertSet) begin
      alertActive <= 1'b1; // [RL17] [RL19]
      if (convDone) begin
        alertCause <= violHigh; // [RL22]
      end
    end else if (alertClr) begin
      alertActive <= 1'b0; // [RL21]
    end
  end

  // Both pins only ever pull low; the enable marks the active alarm.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      criticalAlarmOut  <= 1'b0;
      criticalAlarmOe   <= 1'b0;
      sharedAlarmPinOut <= 1'b0;
      sharedAlarmPinOe  <= 1'b0;
    end else begin
      criticalAlarmOe <= critActive; // [RL12] [RL14]
      if (functionSecondCrit) begin
        sharedAlarmPinOe <= crit2Active; // [RL13] [RL16]
      end else begin
        sharedAlarmPinOe <= alertActive & ~alertMasked; // [RL12] [RL20]
      end
    end
  end
endmodule // tma_bus_alarm_top
`default_nettype wire

/* src/tma_fifo.sv */
// Purpose: Word buffer with valid and ready on both sides.
// Assumes: DEPTH is a power of two, at least two.
// Notes:   Ready on the fill side drops only when every slot is taken.
`timescale 1ns/1ns
`default_nettype none
module tma_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Streams
  tma_stream_if.snk push,
  tma_stream_if.src pop
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gBadDepth
      $error("tma_fifo depth must be a power of two");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrIdx;
  logic [AW-1:0]    rdIdx;
  logic [AW:0]      count;
  logic             doPush;
  logic             doPop;

  assign push.ready = (count != (AW+1)'(DEPTH));
  assign pop.valid  = (count != '0);
  assign pop.data   = mem[rdIdx];
  assign doPush     = push.valid & push.ready;
  assign doPop      = pop.valid & pop.ready;

  always_ff @(posedge clock) begin
    if (doPush) begin
      mem[wrIdx] <= push.data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrIdx <= '0;
      rdIdx <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrIdx <= wrIdx + AW'(1);
      end
      if (doPop) begin
        rdIdx <= rdIdx + AW'(1);
      end
      if (doPush && !doPop) begin
        count <= count + (AW+1)'(1);
      end else if (doPop && !doPush) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule // tma_fifo
`default_nettype wire

/* src/tma_pkg.sv */
// Purpose: Shared constants of the temperature monitor bus and alarm logic.
// Assumes: A 10 MHz system clock.
// Notes:   The offsets, field positions, local register reset values and timing counts of the design live here.
package tma_pkg;
  // ------------
  // Clock and timing
  // ------------
  localparam int CLK_KHZ        = 10000;
  localparam int TIMEOUT_MS     = 32;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;
  localparam int FILT_FAST      = 2;
  localparam int FILT_HS        = 0;

  // ------------
  // Bus codes
  // ------------
  localparam logic [7:0] ALERT_RESPONSE_BYTE = 8'h19;
  localparam logic [4:0] HS_CODE_TOP         = 5'h01;

  // ------------
  // Local registers
  // ------------
  localparam logic [7:0] PTR_HYST   = 8'h21;
  localparam logic [7:0] PTR_CONSEC = 8'h22;
  localparam logic [7:0] HYST_POR   = 8'h0A;
  localparam logic [7:0] CONSEC_POR = 8'h70;
  localparam int         CALT_LSB   = 1;
  localparam int         CALT_MSB   = 2;

  // ------------
  // Configuration bits
  // ------------
  localparam int CFG_FUNC_BIT = 5;
  localparam int CFG_MASK_BIT = 7;

  // ------------
  // Write buffer
  // ------------
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 16;
endpackage

/* src/tma_stream_if.sv */
// Purpose: Valid/ready carrier between the bus logic and its write buffer.
// Assumes: One clock domain on both ends.
// Notes:   A word moves when valid and ready are both high at a clock edge.
`timescale 1ns/1ns
`default_nettype none
interface tma_stream_if #(parameter int WIDTH = 16);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* tb/tma_bus_alarm_monitor.sv */
// Purpose: Port checks for tma_bus_alarm_top.
// Assumes: One clock domain.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module tma_bus_alarm_monitor #(parameter int TIMEOUT_CYCLES = 200) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // Bus
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       highSpeedBusOperation,
  // Alarms
  input wire logic       convDone,
  input wire logic       remoteOpen,
  input wire logic [7:0] localTemp,
  input wire logic [7:0] localCritLimit,
  input wire logic [7:0] localHighLimit,
  input wire logic [7:0] configBits,
  input wire logic       criticalAlarmOut,
  input wire logic       criticalAlarmOe,
  input wire logic       sharedAlarmPinOut,
  input wire logic       sharedAlarmPinOe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Counts cycles since both bus lines were last seen high together.
  int lowRun;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      lowRun <= 0;
    else if (sclIn && sdaIn)
      lowRun <= 0;
    else
      lowRun <= lowRun + 1;
  end
  sequence s_hotCrit;
    convDone && localTemp > localCritLimit ##1 !convDone;
  endsequence
  sequence s_hotHigh;
    configBits[5] && convDone && localTemp > localHighLimit ##1 !convDone;
  endsequence
  property p_pinsLow;
    !sdaOut && !criticalAlarmOut && !sharedAlarmPinOut;
  endproperty
  a_pinsLow: assert property (p_pinsLow) else $error("pin driven high");
  property p_critSet;
    s_hotCrit |-> ##1 criticalAlarmOe;
  endproperty
  a_critSet: assert property (p_critSet) else $error("critical alarm late");
  property p_critMove;
    $changed(criticalAlarmOe) |-> $past(convDone, 2);
  endproperty
  a_critMove: assert property (p_critMove) else $error("critical moved alone");
  property p_second;
    s_hotHigh |-> ##1 sharedAlarmPinOe;
  endproperty
  a_second: assert property (p_second) else $error("second critical late");
  property p_mask;
    (configBits[7] && !configBits[5]) [*3] |-> !sharedAlarmPinOe;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alert active");
  property p_alertCause;
    $rose(sharedAlarmPinOe) && configBits == $past(configBits, 3) && configBits[7:5] == 3'h0
      |-> $past(convDone, 2) || $past(remoteOpen) || $past(remoteOpen, 2);
  endproperty
  a_alertCause: assert property (p_alertCause) else $error("alert without cause");
  property p_hsExit;
    $fell(highSpeedBusOperation) |-> $past(sclIn, 3) && $past(sdaIn, 3);
  endproperty
  a_hsExit: assert property (p_hsExit) else $error("fast mode without stop");
  property p_timeout;
    lowRun > TIMEOUT_CYCLES + 8 |-> !sdaOe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("data line held past timeout");
endmodule // tma_bus_alarm_monitor
bind tma_bus_alarm_top tma_bus_alarm_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_mon (.*);
`default_nettype wire

/* tb/tma_bus_alarm_top_tb.sv */
// Purpose: Self-checking bench for tma_bus_alarm_top.
// Assumes: tma_bus_master drives the bus pins.
// Notes:   Timeout and buffer depth are shortened.
`timescale 1ns/1ns
`default_nettype none
module tma_bus_alarm_top_tb;
  localparam logic [6:0] ADDR = 7'h2A;
  logic       clock, resetn, scl, sdaDrv, sdaLine, sdaOe, hs, wrValid, wrReady, convDone;
  logic       remoteOpen, statusCleared, critOe, sharedOe;
  logic [7:0] regPointer, readData, wrPointer, wrData, localTemp, cfg;
  logic [7:0] crit = 8'h50, high = 8'h40, low = 8'h10;
  int         errCount = 0;
  int         totalChecks = 0;
  assign sdaLine = sdaDrv & ~sdaOe;
  tma_bus_master i_master (.clock, .sdaLine, .scl, .sdaDrv);
  tma_bus_alarm_top #(.TIMEOUT_CYCLES(200), .FIFO_DEPTH(4)) i_dut (
    .clock, .resetn, .sclIn(scl), .sdaIn(sdaLine), .sdaOut(), .sdaOe, .slaveAddr(ADDR),
    .highSpeedBusOperation(hs), .regPointer, .readData, .wrValid, .wrReady, .wrPointer,
    .wrData, .convDone, .localTemp, .remoteTemp(8'h20), .localCritLimit(crit),
    .remoteCritLimit(crit), .localHighLimit(high), .remoteHighLimit(high), .localLowLimit(low),
    .remoteLowLimit(low), .remoteOpen, .configBits(cfg), .statusCleared, .criticalAlarmOut(),
    .criticalAlarmOe(critOe), .sharedAlarmPinOut(), .sharedAlarmPinOe(sharedOe));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic wrapUp();
    $display("checks %0d, mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic expAck);
    logic [7:0] rx;
    logic       a;
    i_master.xfer(b, 1'b1, rx, a);
    chk(17'(a), 17'(expAck));
  endtask
  task automatic recv(input logic ackIn, input logic [7:0] exp);
    logic [7:0] rx;
    logic       a;
    i_master.xfer(8'hFF, ackIn, rx, a);
    chk(17'(rx), 17'(exp));
  endtask
  task automatic wreg(input logic [7:0] ptr, input logic [7:0] d);
    i_master.start_cond();
    send({ADDR, 1'b0}, 1'b0);
    send(ptr, 1'b0);
    send(d, 1'b0);
    i_master.stop_cond();
  endtask
  task automatic trip(input logic [7:0] t, input logic ec, input logic es);
    localTemp <= t;
    convDone <= 1'b1;
    @(posedge clock);
    convDone <= 1'b0;
    repeat (3) @(posedge clock);
    chk(17'({critOe, sharedOe}), 17'({ec, es}));
  endtask
  task automatic alertResp(input logic expOe);
    i_master.start_cond();
    send(8'h19, 1'b0);
    recv(1'b1, {ADDR, 1'b1});
    i_master.stop_cond();
    chk(17'(sharedOe), 17'(expOe));
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    errCount++;
    wrapUp();
  end
  initial begin
    {resetn, convDone, wrReady, remoteOpen, statusCleared} = 5'h00;
    {readData, localTemp, cfg} = {8'h96, 8'h20, 8'hA0};
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    i_master.start_cond();
    send({ADDR, 1'b0}, 1'b0);
    send(8'h10, 1'b0);
    for (int i = 1; i <= 5; i++)
      send(8'(i * 17), 1'(i == 5));
    i_master.stop_cond();
    chk(17'(regPointer), 17'h10);
    for (int i = 1; i <= 4; i++) begin
      chk({wrValid, wrPointer, wrData}, {1'b1, 8'h10, 8'(i * 17)});
      wrReady <= 1'b1;
      @(posedge clock);
      wrReady <= 1'b0;
      @(posedge clock);
    end
    chk(17'(wrValid), 17'h0);
    wrReady <= 1'b1;
    i_master.start_cond();
    send({ADDR, 1'b1}, 1'b0);
    recv(1'b0, 8'h96);
    recv(1'b1, 8'h96);
    i_master.start_cond();
    send({ADDR ^ 7'h01, 1'b0}, 1'b1);
    i_master.start_cond();
    send(8'h0B, 1'b1);
    i_master.start_cond();
    send({ADDR, 1'b0}, 1'b0);
    chk(17'(hs), 17'h1);
    i_master.stop_cond();
    chk(17'(hs), 17'h0);
    readData <= 8'h3C;
    i_master.start_cond();
    send({ADDR, 1'b1}, 1'b0);
    i_master.hold_low(12);
    chk(17'(sdaOe), 17'h1);
    i_master.hold_low(250);
    chk(17'(sdaOe), 17'h0);
    i_master.stop_cond();
    wreg(8'h21, 8'h05);
    trip(8'h51, 1'b1, 1'b1);
    trip(8'h4C, 1'b1, 1'b1);
    trip(8'h4B, 1'b0, 1'b1);
    trip(8'h3C, 1'b0, 1'b1);
    trip(8'h3B, 1'b0, 1'b0);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    wreg(8'h22, 8'h04);
    cfg <= 8'h00;
    for (int i = 0; i < 6; i++)
      trip(i == 2 ? 8'h20 : 8'h40, 1'b0, 1'(i == 5));
    cfg <= 8'h80;
    repeat (4) @(posedge clock);
    chk(17'(sharedOe), 17'h0);
    cfg <= 8'h00;
    repeat (4) @(posedge clock);
    chk(17'(sharedOe), 17'h1);
    alertResp(1'b1);
    trip(8'h20, 1'b0, 1'b1);
    statusCleared <= 1'b1;
    alertResp(1'b0);
    remoteOpen <= 1'b1;
    repeat (4) @(posedge clock);
    chk(17'(sharedOe), 17'h1);
    wrapUp();
  end
endmodule // tma_bus_alarm_top_tb
`default_nettype wire

/* tb/tma_bus_master.sv */
// Purpose: Behavioural two-wire bus master.
// Assumes: Pull-ups on both lines; sixteen system clocks per bit.
// Notes:   Lines change only just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module tma_bus_master (
  // Clock
  input wire logic clock,
  // Bus lines
  input wire logic sdaLine,
  output var logic scl,
  output var logic sdaDrv
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    tick(1);
    sdaDrv <= b;
    tick(7);
    scl <= 1'b1;
    tick(8);
    r = sdaLine;
  endtask
  task automatic start_cond();
    logic r;
    if (!sdaLine)
      bit_io(1'b1, r);
    sdaDrv <= 1'b0;
    tick(4);
  endtask
  task automatic stop_cond();
    logic r;
    bit_io(1'b0, r);
    sdaDrv <= 1'b1;
    tick(8);
  endtask
  // The acknowledge slot is driven with ackIn: low to continue a read, high to end it.
  task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
                      output logic ackOut);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ackIn, ackOut);
  endtask
  task automatic hold_low(input int n);
    scl <= 1'b0;
    tick(n);
  endtask
endmodule // tma_bus_master
`default_nettype wire
